// ==== pkg/prca_pkg.sv ====
// Purpose: Shared constants and types for the counter array.
// Assumes: Register port is 8-bit address, 16-bit data.
// Notes: Offsets are word indices on the plain register port.
package prca_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_MOD = 3;
  localparam int WD_MOD = 2;
  localparam int NUM_SYNC = NUM_MOD + 3;
  localparam int SYNC_EXT = NUM_MOD;
  localparam int SYNC_XOSC = NUM_MOD + 1;
  localparam int SYNC_RTC = NUM_MOD + 2;
  localparam int SYNC_STAGES = 2;

  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_MASK = 8'h03;
  localparam logic [7:0] REG_WDOG = 8'h04;
  localparam logic [7:0] REG_KICK = 8'h05;
  localparam logic [7:0] REG_MODE0 = 8'h08;
  localparam logic [7:0] REG_CMP0 = 8'h0c;
  localparam logic [7:0] REG_CAPT0 = 8'h10;

  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_W = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int PWM_LSB = 3;
  localparam int PWM_W = 3;
  localparam int POS_BIT = 6;
  localparam int NEG_BIT = 7;
  localparam int STAT_OVF = 0;
  localparam int STAT_MOD = 1;
  localparam int STAT_W = NUM_MOD + 1;
  localparam int WD_EN_BIT = 0;
  localparam int WD_LOCK_BIT = 1;

  // Reset values and divider counts.
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [15:0] WD_CMP_RST = 16'hffff;
  localparam logic [15:0] WD_SPAN_RST = 16'h8000;
  localparam int DIV12 = 12;
  localparam int DIV4 = 4;
  localparam int DIV8 = 8;

  typedef enum logic [2:0] {
    CLK_DIV12, CLK_DIV4, CLK_T0, CLK_EXT, CLK_SYS, CLK_XOSC8, CLK_RTC8
  } prca_clk_t;

  typedef enum logic [MODE_W-1:0] {
    MODE_OFF, MODE_CAPTURE, MODE_TIMER, MODE_HSO, MODE_PWM, MODE_FREQ,
    MODE_WDOG
  } prca_mode_t;

  // Mask of the counter bits that one PWM period spans.
  function automatic logic [15:0] pwm_mask(input logic [PWM_W-1:0] sel);
    case (sel)
      3'h0: return 16'h00ff;
      3'h1: return 16'h01ff;
      3'h2: return 16'h03ff;
      3'h3: return 16'h07ff;
      default: return 16'hffff;
    endcase
  endfunction
endpackage

// ==== pkg/prca_mod_if.sv ====
// Purpose: Link between the time base core and one compare unit.
// Assumes: Both ends run on sys_clk.
// Notes: Pin input is already synchronised by the core.
`timescale 1ns/1ns
interface prca_mod_if;
  import prca_pkg::*;
  logic tick;
  logic [15:0] count;
  prca_mode_t mode;
  logic [PWM_W-1:0] pwm_sel;
  logic pos_en;
  logic neg_en;
  logic [15:0] cmp;
  logic pin_in;
  logic pin_out;
  logic event_p;
  logic [15:0] capt;
  modport core (
    output tick, count, mode, pwm_sel, pos_en, neg_en, cmp, pin_in,
    input pin_out, event_p, capt
  );
  modport unit (
    input tick, count, mode, pwm_sel, pos_en, neg_en, cmp, pin_in,
    output pin_out, event_p, capt
  );
endinterface

// ==== hw/prca_unit.sv ====
// Purpose: One capture/compare unit of the counter array.
// Assumes: Count and tick come from the shared time base.
// Notes: Events are registered one cycle after their cause.
`timescale 1ns/1ns
module prca_unit
  import prca_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Core link
  prca_mod_if.unit bus
);
  logic pin_d_ff;
  logic out_ff;
  logic evt_ff;
  logic [15:0] capt_ff;
  logic [7:0] fdiv_ff;
  logic nxt_out;
  logic nxt_evt;
  logic [15:0] nxt_capt;

  wire [15:0] pmask = pwm_mask(bus.pwm_sel);
  wire [15:0] cnt_f = bus.count & pmask;
  wire [15:0] cmp_f = bus.cmp & pmask;
  wire hit_full = bus.tick & (bus.count == bus.cmp);
  wire pwm_end = bus.tick & (cnt_f == pmask);
  wire rise = bus.pin_in & ~pin_d_ff & bus.pos_en;
  wire fall = ~bus.pin_in & pin_d_ff & bus.neg_en;
  wire edge_hit = rise | fall;
  wire fdiv_zero = (fdiv_ff == 8'h00);
  wire freq_tog = bus.tick & fdiv_zero;

  // Mode selection of event and output behaviour.
  always_comb begin
    nxt_out = out_ff;
    nxt_evt = 1'b0;
    nxt_capt = capt_ff;
    unique case (bus.mode) // [RULE_03]
      MODE_OFF: begin
        nxt_out = 1'b0;
      end
      MODE_CAPTURE: begin
        nxt_evt = edge_hit; // [RULE_11]
        if (edge_hit) begin
          nxt_capt = bus.count;
        end
      end
      MODE_TIMER, MODE_WDOG: begin
        nxt_evt = hit_full;
      end
      MODE_HSO: begin
        nxt_evt = hit_full;
        if (hit_full) begin
          nxt_out = ~out_ff;
        end
      end
      MODE_PWM: begin
        nxt_out = (cnt_f < cmp_f); // [RULE_04]
        nxt_evt = pwm_end;
      end
      MODE_FREQ: begin
        nxt_evt = freq_tog;
        if (freq_tog) begin
          nxt_out = ~out_ff;
        end
      end
      default: begin
        nxt_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_d_ff <= 1'b0;
      out_ff <= 1'b0;
      evt_ff <= 1'b0;
      capt_ff <= 16'h0000;
      fdiv_ff <= 8'h00;
    end else begin
      pin_d_ff <= bus.pin_in;
      out_ff <= nxt_out;
      evt_ff <= nxt_evt;
      capt_ff <= nxt_capt;
      if (bus.tick) begin
        fdiv_ff <= fdiv_zero ? bus.cmp[15:8] : fdiv_ff - 8'h01;
      end
    end
  end

  assign bus.pin_out = out_ff;
  assign bus.event_p = evt_ff;
  assign bus.capt = capt_ff;
endmodule

// ==== hw/prca_top.sv ====
// Purpose: Counter array with a shared time base and three units.
// Assumes: Plain register port; pins arrive through the crossbar.
// Notes: Unit 2 starts as an armed watchdog after every reset.
// Operation
// RULE_01: One 16-bit time base feeding three units.
// RULE_02: Time base clock chosen from seven sources.
// RULE_03: Units do capture, timer, toggle, PWM, frequency.
// RULE_04: PWM widths of 8, 9, 10, 11, 16 bits.
// RULE_05: Only unit 2 may act as watchdog.
// RULE_06: Watchdog armed on unit 2 after reset.
// RULE_07: Software may lock the watchdog off.
// RULE_08: Watchdog timeout requests a system reset.
// RULE_09: Unit pins and count input via crossbar.
// RULE_10: Count increments per tick, wraps, flags overflow.
// RULE_11: Pin inputs synchronised before edge detection.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module prca_top
  import prca_pkg::*;
#(
  parameter logic [15:0] WD_SPAN = WD_SPAN_RST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Clock sources
  input wire logic t0_ovf,
  input wire logic ext_osc_in,
  input wire logic rtc_osc_in,
  // Crossbar side
  input wire logic ext_count_input,
  input wire logic [NUM_MOD-1:0] xbar_mod_in,
  output logic [NUM_MOD-1:0] xbar_mod_out,
  // System
  output logic irq,
  output logic sys_reset_req
);
  localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);
  localparam logic [1:0] DIV4_LAST = 2'(DIV4 - 1);
  localparam logic [2:0] DIV8_LAST = 3'(DIV8 - 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction

  logic [NUM_SYNC-1:0] sync1_ff;
  logic [NUM_SYNC-1:0] sync2_ff;
  logic [NUM_SYNC-1:0] prev_ff;
  logic [3:0] div12_ff;
  logic [1:0] div4_ff;
  logic [2:0] xosc8_ff;
  logic [2:0] rtc8_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [15:0] count_ff;
  logic [STAT_W-1:0] status_ff;
  logic [STAT_W-1:0] mask_ff;
  logic wd_en_ff;
  logic wd_lock_ff;
  logic rst_req_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [NUM_MOD-1:0] evt;
  logic [NUM_MOD-1:0] unit_out;
  logic [DATA_W-1:0] rd_acc [NUM_MOD+1];

  // Pin inputs pass two flops before any edge logic.
  wire [NUM_SYNC-1:0] pin_raw = {rtc_osc_in, ext_osc_in, ext_count_input,
                                 xbar_mod_in}; // [RULE_09]
  wire [NUM_SYNC-1:0] rise = sync2_ff & ~prev_ff; // [RULE_11]

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Clock source dividers.
  wire tick12 = (div12_ff == DIV12_LAST);
  wire tick4 = (div4_ff == DIV4_LAST);
  wire tick_xosc = rise[SYNC_XOSC] & (xosc8_ff == DIV8_LAST);
  wire tick_rtc = rise[SYNC_RTC] & (rtc8_ff == DIV8_LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div12_ff <= 4'h0;
      div4_ff <= 2'h0;
      xosc8_ff <= 3'h0;
      rtc8_ff <= 3'h0;
    end else begin
      div12_ff <= tick12 ? 4'h0 : div12_ff + 4'h1;
      div4_ff <= div4_ff + 2'h1;
      xosc8_ff <= xosc8_ff + {2'h0, rise[SYNC_XOSC]};
      rtc8_ff <= rtc8_ff + {2'h0, rise[SYNC_RTC]};
    end
  end

  // Source select; code seven gives no tick.
  wire [7:0] src_vec = {1'b0, tick_rtc, tick_xosc, 1'b1, rise[SYNC_EXT],
                        t0_ovf, tick4, tick12}; // [RULE_02]
  wire [2:0] clk_sel = ctrl_ff[CTRL_SEL +: 3];
  wire run_en = ctrl_ff[CTRL_RUN] | wd_en_ff;
  wire tb_tick = run_en & src_vec[clk_sel];
  wire tb_wrap = tb_tick & (count_ff == 16'hffff);

  // Register write decode.
  wire wr_ctrl = reg_wr & hit(reg_addr, REG_CTRL);
  wire wr_count = reg_wr & hit(reg_addr, REG_COUNT);
  wire wr_status = reg_wr & hit(reg_addr, REG_STATUS);
  wire wr_mask = reg_wr & hit(reg_addr, REG_MASK);
  wire wr_wdog = reg_wr & hit(reg_addr, REG_WDOG);
  wire wr_kick = reg_wr & hit(reg_addr, REG_KICK);

  // Time base: one shared 16-bit counter.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_ff <= 16'h0000;
    end else if (wr_count) begin
      count_ff <= reg_wdata;
    end else if (tb_tick) begin
      count_ff <= count_ff + 16'h0001; // [RULE_01] [RULE_10]
    end
  end

  // Sticky status; a new event wins over a clear.
  wire [STAT_W-1:0] stat_set = {evt, tb_wrap}; // [RULE_10]
  wire [STAT_W-1:0] stat_clr = wr_status ? reg_wdata[STAT_W-1:0] : '0;
  wire [STAT_W-1:0] nxt_status = (status_ff & ~stat_clr) | stat_set;

  // Watchdog lock only takes effect when disabling.
  wire wd_free = wr_wdog & ~wd_lock_ff;
  wire nxt_wd_en = wd_free ? reg_wdata[WD_EN_BIT] : wd_en_ff;
  wire nxt_wd_lock = wd_lock_ff |
                     (wd_free & ~reg_wdata[WD_EN_BIT] &
                      reg_wdata[WD_LOCK_BIT]); // [RULE_07]
  wire wd_timeout = evt[WD_MOD] & wd_en_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_ff <= CTRL_RST;
      status_ff <= '0;
      mask_ff <= '0;
      wd_en_ff <= 1'b1; // [RULE_06]
      wd_lock_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[CTRL_W-1:0];
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata[STAT_W-1:0];
      end
      status_ff <= nxt_status;
      wd_en_ff <= nxt_wd_en;
      wd_lock_ff <= nxt_wd_lock;
      rst_req_ff <= wd_timeout; // [RULE_08]
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // Core register read mux.
  assign rd_acc[0] =
    hit(reg_addr, REG_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff} :
    hit(reg_addr, REG_COUNT) ? count_ff :
    hit(reg_addr, REG_STATUS) ? {{(DATA_W-STAT_W){1'b0}}, status_ff} :
    hit(reg_addr, REG_MASK) ? {{(DATA_W-STAT_W){1'b0}}, mask_ff} :
    hit(reg_addr, REG_WDOG) ? {14'h0000, wd_lock_ff, wd_en_ff} :
    16'h0000;

  // Capture/compare units.
  for (genvar m = 0; m < NUM_MOD; m++) begin : g_unit
    localparam logic [ADDR_W-1:0] A_MODE = REG_MODE0 + ADDR_W'(m);
    localparam logic [ADDR_W-1:0] A_CMP = REG_CMP0 + ADDR_W'(m);
    localparam logic [ADDR_W-1:0] A_CAPT = REG_CAPT0 + ADDR_W'(m);
    localparam bit IS_WD = (m == WD_MOD);
    prca_mod_if uif ();
    prca_mode_t mode_ff;
    logic [PWM_W-1:0] pwm_ff;
    logic pos_ff;
    logic neg_ff;
    logic [15:0] cmp_ff;
    wire wr_mode = reg_wr & hit(reg_addr, A_MODE);
    wire wr_cmp = reg_wr & hit(reg_addr, A_CMP);
    wire kick = IS_WD & wr_kick;
    wire prca_mode_t req_mode = prca_mode_t'(reg_wdata[MODE_LSB +: MODE_W]);
    wire bad_wd = ~IS_WD & (req_mode == MODE_WDOG); // [RULE_05]
    wire prca_mode_t wr_val = bad_wd ? MODE_OFF : req_mode;

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        mode_ff <= IS_WD ? MODE_WDOG : MODE_OFF; // [RULE_06]
        pwm_ff <= '0;
        pos_ff <= 1'b0;
        neg_ff <= 1'b0;
        cmp_ff <= IS_WD ? WD_CMP_RST : 16'h0000;
      end else begin
        if (IS_WD & wd_en_ff) begin
          mode_ff <= MODE_WDOG; // [RULE_05] [RULE_06]
        end else if (wr_mode) begin
          mode_ff <= wr_val;
        end
        if (wr_mode) begin
          pwm_ff <= reg_wdata[PWM_LSB +: PWM_W];
          pos_ff <= reg_wdata[POS_BIT];
          neg_ff <= reg_wdata[NEG_BIT];
        end
        if (kick) begin
          cmp_ff <= count_ff + WD_SPAN;
        end else if (wr_cmp) begin
          cmp_ff <= reg_wdata;
        end
      end
    end

    assign uif.tick = tb_tick;
    assign uif.count = count_ff;
    assign uif.mode = mode_ff;
    assign uif.pwm_sel = pwm_ff;
    assign uif.pos_en = pos_ff;
    assign uif.neg_en = neg_ff;
    assign uif.cmp = cmp_ff;
    assign uif.pin_in = sync2_ff[m]; // [RULE_11]
    assign evt[m] = uif.event_p;
    assign unit_out[m] = uif.pin_out;
    assign rd_acc[m+1] = rd_acc[m] |
      (hit(reg_addr, A_MODE) ?
        {8'h00, neg_ff, pos_ff, pwm_ff, mode_ff} : 16'h0000) |
      (hit(reg_addr, A_CMP) ? cmp_ff : 16'h0000) |
      (hit(reg_addr, A_CAPT) ? uif.capt : 16'h0000);

    prca_unit u_unit (
      .sys_clk(sys_clk),
      .reset(reset),
      .bus(uif.unit)
    );
  end

  // Read data stand for one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rd_acc[NUM_MOD] : '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign xbar_mod_out = unit_out; // [RULE_09]
  assign irq = irq_ff;
  assign sys_reset_req = rst_req_ff;

  // Checks.
  wire sel12 = (clk_sel == CLK_DIV12);
  wire sel_ext = (clk_sel == CLK_EXT);
  wire sel_sys = (clk_sel == CLK_SYS);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  count_step_a: assert property ( // [RULE_10]
    tb_tick && !wr_count |=> count_ff == $past(count_ff) + 16'h0001
  ) else $error("time base did not advance on a tick");

  count_hold_a: assert property ( // [RULE_10]
    !tb_tick && !wr_count |=> $stable(count_ff)
  ) else $error("time base moved without a tick");

  wrap_flag_a: assert property ( // [RULE_10]
    tb_wrap |=> status_ff[STAT_OVF] && count_ff == 16'h0000
  ) else $error("wrap did not set overflow");

  div12_gap_a: assert property ( // [RULE_02]
    sel12 && tb_tick |=> (!tb_tick || !sel12) [*8]
  ) else $error("divide by twelve ticked too soon");

  ext_once_a: assert property ( // [RULE_11]
    sel_ext && tb_tick |=> !tb_tick || !sel_ext
  ) else $error("count input edge seen twice");

  wd_reset_a: assert property ( // [RULE_08]
    g_unit[WD_MOD].uif.event_p && wd_en_ff |=> sys_reset_req
  ) else $error("watchdog timeout gave no reset request");

  wd_lock_a: assert property ( // [RULE_07]
    wd_lock_ff |-> !wd_en_ff ##1 wd_lock_ff
  ) else $error("locked watchdog came back");

  wd_boot_a: assert property ( // [RULE_06]
    $fell(reset) |-> wd_en_ff && g_unit[WD_MOD].mode_ff == MODE_WDOG
  ) else $error("watchdog not armed after reset");

  wd_only2_a: assert property ( // [RULE_05]
    g_unit[0].mode_ff != MODE_WDOG && g_unit[1].mode_ff != MODE_WDOG
  ) else $error("watchdog mode on a unit other than 2");

  rst_pulse_a: assert property ( // [RULE_08]
    sys_reset_req |=> !sys_reset_req
  ) else $error("reset request longer than one cycle");

  wd_mode_a: assert property ( // [RULE_06]
    wd_en_ff |=> g_unit[WD_MOD].mode_ff == MODE_WDOG
  ) else $error("armed watchdog lost its unit mode");

  ovf_sticky_a: assert property ( // [RULE_10]
    status_ff[STAT_OVF] && !(wr_status && reg_wdata[STAT_OVF])
    |=> status_ff[STAT_OVF]
  ) else $error("overflow flag dropped without a clear");

  ovf_clear_a: assert property ( // [RULE_10]
    wr_status && reg_wdata[STAT_OVF] && !tb_wrap |=> !status_ff[STAT_OVF]
  ) else $error("overflow flag survived its clear");

  irq_follow_a: assert property ( // [RULE_10]
    $rose(status_ff[STAT_OVF]) && $past(mask_ff[STAT_OVF]) |-> irq
  ) else $error("unmasked overflow gave no interrupt");

  sys_tick_a: assert property ( // [RULE_02]
    sel_sys && run_en && !wr_count |=> count_ff != $past(count_ff)
  ) else $error("system clock source missed a tick");

  wd_timeout_c: cover property (wd_timeout ##1 sys_reset_req);
  wrap_c: cover property (tb_wrap);
  capture_c: cover property (
    g_unit[0].mode_ff == MODE_CAPTURE && g_unit[0].uif.event_p);
  lock_c: cover property ($rose(wd_lock_ff));
  pwm_c: cover property (
    g_unit[0].mode_ff == MODE_PWM && $rose(xbar_mod_out[0]));
endmodule

// ==== verif/prca_pins.sv ====
// Purpose: Pin side model of oscillators, overflow, count and capture pins.
// Assumes: Oscillators run slower than a quarter of sys_clk.
// Notes: Capture levels follow cap_lvl one clock edge later.
`timescale 1ns/1ns
module prca_pins (
  // Clock
  input wire logic sys_clk,
  // Bench control
  input wire logic [2:0] cap_lvl,
  // Pin side
  output logic t0_ovf,
  output logic ext_osc_in,
  output logic rtc_osc_in,
  output logic ext_count_input,
  output logic [2:0] xbar_mod_in
);
  int cnt_ff = 0;
  initial begin
    t0_ovf = 1'b0;
    ext_osc_in = 1'b0;
    rtc_osc_in = 1'b0;
    ext_count_input = 1'b0;
    xbar_mod_in = 3'h0;
  end
  // Overflow pulse one cycle in eight, count input period of eight cycles.
  always @(posedge sys_clk) begin
    cnt_ff <= cnt_ff + 1;
    t0_ovf <= (cnt_ff % 8) == 7;
    ext_count_input <= (cnt_ff % 8) >= 4;
    xbar_mod_in <= cap_lvl;
  end
  // Free running oscillators, out of phase with sys_clk.
  always #30 ext_osc_in = ~ext_osc_in;
  initial begin
    #3;
    forever #50 rtc_osc_in = ~rtc_osc_in;
  end
endmodule

// ==== verif/programmable_counter_array_test.sv ====
// Purpose: Self-checking bench for the counter array.
// Assumes: Watchdog span shortened to 16'h0040.
// Notes: Expected values come from the model array and fixed rates.
`timescale 1ns/1ns
module programmable_counter_array_test;
  import prca_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic t0_ovf, ext_osc_in, rtc_osc_in, ext_count_input;
  logic irq, sys_reset_req, lvl;
  logic [2:0] xbar_mod_in, xbar_mod_out;
  logic [2:0] cap_lvl = 3'h0;
  int err_total = 0;
  int n_tests = 0;
  int seed = 32'hca42;
  int n, i;
  int mdl[int];
  int nom[7] = '{20, 60, 30, 30, 242, 5, 3};
  int pw[5] = '{512, 512, 512, 1024, 1024};

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  prca_top #(.WD_SPAN(16'h0040)) u_prca_top (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .t0_ovf(t0_ovf), .ext_osc_in(ext_osc_in),
    .rtc_osc_in(rtc_osc_in), .ext_count_input(ext_count_input),
    .xbar_mod_in(xbar_mod_in), .xbar_mod_out(xbar_mod_out), .irq(irq),
    .sys_reset_req(sys_reset_req)
  );
  prca_pins u_prca_pins (
    .sys_clk(sys_clk), .cap_lvl(cap_lvl), .t0_ovf(t0_ovf),
    .ext_osc_in(ext_osc_in), .rtc_osc_in(rtc_osc_in),
    .ext_count_input(ext_count_input), .xbar_mod_in(xbar_mod_in)
  );

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    mdl[a] = d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(rd_val, e);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic run_for(input logic [15:0] ctrl, input int cyc);
    wr(REG_CTRL, ctrl);
    repeat (cyc) @(posedge sys_clk);
    wr(REG_CTRL, 16'h0000);
  endtask

  initial begin
    do_reset();
    rd_chk(REG_WDOG, 16'h0001);
    rd_chk(REG_MODE0 + 8'h02, 16'h0006);
    rd_chk(REG_CMP0 + 8'h02, WD_CMP_RST);
    rd_chk(REG_CTRL, 16'h0000);
    wr(REG_MODE0 + 8'h02, 16'h0002);
    rd_chk(REG_MODE0 + 8'h02, 16'h0006);
    wr(REG_MODE0, 16'h0006);
    rd_chk(REG_MODE0, 16'h0000);
    wr(8'h07, 16'h1234);
    rd_chk(8'h07, 16'h0000);
    // Kick, then wait for the timeout of 64 ticks at a twelfth of sys_clk.
    wr(REG_KICK, 16'h0000);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 2000) begin
      err_total++;
    end
    chk(16'(n >= 740 && n <= 800), 16'h0001);
    @(posedge sys_clk);
    #1 chk({15'h0, sys_reset_req}, 16'h0000);
    do_reset();
    rd_chk(REG_WDOG, 16'h0001);
    wr(REG_WDOG, 16'h0002);
    wr(REG_WDOG, 16'h0001);
    rd_chk(REG_WDOG, 16'h0002);
    wr(REG_COUNT, 16'h0100);
    repeat (50) @(posedge sys_clk);
    rd_chk(REG_COUNT, 16'h0100);
    for (i = 0; i < 3; i++) begin
      n = $random(seed);
      wr(REG_CMP0 + 8'(i), n[15:0]);
      rd_chk(REG_CMP0 + 8'(i), 16'(mdl[REG_CMP0 + 8'(i)]));
    end
    // Each clock source over one window from a zero count.
    for (i = 0; i < 7; i++) begin
      wr(REG_COUNT, 16'h0000);
      run_for(16'(i * 2 + 1), 240);
      rd(REG_COUNT);
      chk(16'(rd_val >= nom[i] - 3 && rd_val <= nom[i] + 3), 16'h0001);
    end
    wr(REG_COUNT, 16'h0000);
    run_for(16'h000f, 240);
    rd_chk(REG_COUNT, 16'h0000);
    // Wrap sets the overflow flag; the mask gates the interrupt.
    wr(REG_STATUS, 16'h000f);
    wr(REG_MASK, 16'h0001);
    wr(REG_MODE0, 16'h0002);
    wr(REG_CMP0, 16'hfff8);
    wr(REG_COUNT, 16'hfff0);
    run_for(16'h0009, 40);
    #1 chk({15'h0, irq}, 16'h0001);
    rd(REG_STATUS);
    chk(rd_val & 16'h0001, 16'h0001);
    chk(rd_val & 16'h0002, 16'h0002);
    wr(REG_MASK, 16'h0000);
    rd(REG_STATUS);
    chk({15'h0, irq}, 16'h0000);
    wr(REG_MASK, 16'h0001);
    wr(REG_STATUS, 16'h000f);
    rd(REG_STATUS);
    chk({15'h0, irq}, 16'h0000);
    chk(rd_val & 16'h0001, 16'h0000);
    // Rising edge capture on unit 0 with a frozen count.
    wr(REG_MODE0, 16'h0041);
    n = $random(seed);
    wr(REG_COUNT, n[15:0]);
    cap_lvl <= 3'h1;
    repeat (8) @(posedge sys_clk);
    rd_chk(REG_CAPT0, n[15:0]);
    rd(REG_STATUS);
    chk(rd_val & 16'h0002, 16'h0002);
    wr(REG_COUNT, ~n[15:0]);
    cap_lvl <= 3'h0;
    repeat (8) @(posedge sys_clk);
    rd_chk(REG_CAPT0, n[15:0]);
    // Toggle on match on unit 1.
    wr(REG_MODE0 + 8'h01, 16'h0003);
    wr(REG_CMP0 + 8'h01, 16'h0010);
    wr(REG_COUNT, 16'h0000);
    #1 lvl = xbar_mod_out[1];
    run_for(16'h0009, 40);
    #1 chk({15'h0, xbar_mod_out[1]}, {15'h0, ~lvl});
    rd(REG_STATUS);
    chk(rd_val & 16'h0004, 16'h0004);
    // Frequency output on unit 1 toggles on a fixed reload.
    wr(REG_MODE0 + 8'h01, 16'h0005);
    wr(REG_CMP0 + 8'h01, 16'h0200);
    wr(REG_CTRL, 16'h0009);
    n = 0;
    lvl = xbar_mod_out[1];
    repeat (300) begin
      @(posedge sys_clk);
      #1 n += int'(xbar_mod_out[1] !== lvl);
      lvl = xbar_mod_out[1];
    end
    wr(REG_CTRL, 16'h0000);
    chk(16'(n >= 50 && n <= 160), 16'h0001);
    // Half duty PWM at each width on unit 0.
    for (i = 0; i < 5; i++) begin
      wr(REG_MODE0, 16'(4 | (i << 3)));
      wr(REG_CMP0, i < 4 ? 16'(128 << i) : 16'h8000);
      wr(REG_COUNT, 16'h0000);
      wr(REG_CTRL, 16'h0009);
      n = 0;
      repeat (1024) begin
        @(posedge sys_clk);
        #1 n += int'(xbar_mod_out[0] === 1'b1);
      end
      wr(REG_CTRL, 16'h0000);
      chk(16'(n >= pw[i] - 4 && n <= pw[i] + 4), 16'h0001);
    end
    end_sim();
  end
endmodule
